// ### hdl/sleep_pkg.sv
// Constants, field layouts and carrier types for the sleep controller.
// Assumes one clock (clk, 125 MHz) and an active-low asynchronous reset.
// Operation
// - Pin change wakes idle/standby; power-down or stopped clock needs async pins.
// - Bus address match and logic interrupts wake unless power-down with leakage reduce.
// - In power-down, lookup table wakes only with filter and edge detect zero.
// - Power-down keeps only periodic timer wake; standby clock wake needs run-in-standby.
// - In standby a peripheral runs and wakes only with its run-in-standby bit.
// - Wake latency is six cycles plus oscillator and regulator start-up if stopped.
// - Idle keeps main clock running; wake takes only six cycles.
// - Standby keeps clock only if needed; deep wake adds oscillator and regulator start-up.
// - Power-down runs only the low-frequency oscillator when detector, watchdog or timer use it.
// - Brown-out fuse value 0x3 holds execution until the detector reports ready.
// - Debug break while asleep wakes the device without pending interrupts.
// - Run-time debugging without break leaves behaviour unchanged.
// - Protected regulator write without timely unlock is ignored.
// - Sleep mode field: idle 0x0, standby 0x1, power-down 0x2, others reserved.
// - Sleep instruction enters sleep only when the sleep enable bit is one.
// - Regulator mode field: automatic 0x0, full drive 0x1, others reserved.
package sleep_pkg;
  localparam logic [0:0] ADDR_SLEEP_CONTROL     = 1'h0;
  localparam logic [0:0] ADDR_REGULATOR_CONTROL = 1'h1;
  localparam int         SLEEP_ENABLE_BIT       = 0;
  localparam int         SLEEP_MODE_LSB         = 1;
  localparam int         POWER_MODE_LSB         = 0;
  localparam int         LEAK_REDUCE_BIT        = 4;
  localparam logic [7:0] SLEEP_CONTROL_MASK     = 8'h0f;
  localparam logic [7:0] REGULATOR_MASK         = 8'h17;
  localparam logic [7:0] RESET_BYTE             = 8'h00;
  localparam logic [2:0] MODE_IDLE              = 3'h0;
  localparam logic [2:0] MODE_STANDBY           = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN        = 3'h2;
  localparam logic [2:0] DRIVE_AUTO             = 3'h0;
  localparam logic [2:0] DRIVE_FULL             = 3'h1;
  localparam logic [1:0] BROWNOUT_WAIT_READY    = 2'h3;
  localparam logic [1:0] LUT_ASYNC_SETTING      = 2'h0;
  localparam int         BASE_LATENCY_CYCLES    = 6;
  localparam int         UNLOCK_WINDOW          = 4;
  localparam int         OSC_STARTUP_NS         = 1000;
  localparam int         REG_STARTUP_NS         = 2000;
  localparam int         CLK_PERIOD_NS          = 8;
  localparam int         OSC_STARTUP_CYCLES     = (OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         REG_STARTUP_CYCLES     = (REG_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_SLEEP  = 2'h1,
    ST_WAKE   = 2'h3,
    ST_HOLD   = 2'h2
  } sleep_state_t;

  typedef struct packed {
    logic       pinSync;
    logic       pinAsync;
    logic       brownoutMonitor;
    logic       rtcPeriodic;
    logic       rtcCompare;
    logic       busAddrMatch;
    logic       lutWake;
    logic       frameStart;
    logic       timerAnalog;
    logic       otherIrq;
  } wake_src_t;

  typedef struct packed {
    logic       rtcStandby;
    logic       lutStandby;
    logic       serialStandby;
    logic       timerStandby;
    logic       mainClkStandby;
  } standby_cfg_t;

  typedef struct packed {
    logic [1:0] lutFilterSelect;
    logic [1:0] lutEdgeDetect;
    logic [1:0] brownoutConfigFuse;
    logic       lowFreqUsers;
  } aux_cfg_t;

  typedef struct packed {
    logic       mainClkOn;
    logic       lowFreqOscOn;
    logic       regulatorFull;
    logic       leakReduce;
    logic       cpuHalted;
  } power_out_t;
endpackage : sleep_pkg

// ### hdl/sync_bits.sv
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes inputs are quasi-static relative to clk.
module sync_bits
  import sleep_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output      logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule : sync_bits

// ### hdl/sleep_mode_controller.sv
// Sleep controller: mode registers, wake gating, wake latency, unlock.
// Assumes CPU drives the register port and sleep/key strobes on clk;
// wake sources and break arrive asynchronously and are synchronised here.
module sleep_mode_controller
  import sleep_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_LATENCY_CYCLES,
  parameter int OSC_CYCLES  = OSC_STARTUP_CYCLES,
  parameter int REG_CYCLES  = REG_STARTUP_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [0:0]   regAddr,
  input  wire logic [7:0]   regWdata,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  output      logic [7:0]   regRdata,
  input  wire logic         sleepInstr,
  input  wire logic         keyWritten,
  input  wire logic         instrDone,
  input  wire logic         debugBreak,
  input  wire wake_src_t    wakeSrc,
  input  wire standby_cfg_t standbyCfg,
  input  wire aux_cfg_t     auxCfg,
  input  wire logic         brownoutReady,
  output      power_out_t   powerOut,
  output      logic         wakeEvent
);
  localparam int CW = 16;
  localparam int SW = $bits(wake_src_t) + 2;

  typedef struct packed {
    sleep_state_t state;
    logic [7:0]   sleepCtl;
    logic [7:0]   regCtl;
    logic [2:0]   unlockCnt;
    logic [CW-1:0] latency;
    logic [7:0]   rdata;
    power_out_t   pwr;
    logic         wake;
  } ctl_t;

  ctl_t      s_q;
  ctl_t      s_d;
  wake_src_t src;
  logic      brkSync;
  logic      readySync;

  sync_bits #(.WIDTH(SW)) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn ({wakeSrc, debugBreak, brownoutReady}),
    .syncOut ({src, brkSync, readySync})
  );

  function automatic logic [2:0] field3(input logic [7:0] b, input int lsb);
    field3 = b[lsb+:3];
  endfunction : field3

  logic [2:0] mode;
  logic [2:0] driveMode;
  logic       leak;
  logic       allowed;
  logic       deepWake;
  logic       clkStopped;
  logic       modeValid;

  assign mode  = field3(s_q.sleepCtl, SLEEP_MODE_LSB);
  assign driveMode = field3(s_q.regCtl, POWER_MODE_LSB);
  // Leakage reduce only matters in power-down with automatic regulator
  assign leak  = s_q.regCtl[LEAK_REDUCE_BIT] && driveMode == DRIVE_AUTO;
  assign modeValid = mode == MODE_IDLE || mode == MODE_STANDBY || mode == MODE_POWER_DOWN;

  always_comb begin
    allowed    = 1'b0;
    clkStopped = 1'b0;
    deepWake   = 1'b0;
    case (mode)
      MODE_IDLE: begin
        allowed = |src;
      end
      MODE_STANDBY: begin
        clkStopped = !standbyCfg.mainClkStandby;
        deepWake   = clkStopped;
        allowed = src.pinAsync || (src.pinSync && !clkStopped) || src.brownoutMonitor
          || ((src.rtcPeriodic || src.rtcCompare) && standbyCfg.rtcStandby)
          || src.busAddrMatch
          || (src.lutWake && standbyCfg.lutStandby)
          || (src.frameStart && standbyCfg.serialStandby)
          || (src.timerAnalog && standbyCfg.timerStandby);
      end
      MODE_POWER_DOWN: begin
        clkStopped = 1'b1;
        deepWake   = 1'b1;
        allowed = src.pinAsync || src.brownoutMonitor
          || src.rtcPeriodic
          || (src.busAddrMatch && !leak)
          || (src.lutWake && !leak && auxCfg.lutFilterSelect == LUT_ASYNC_SETTING
              && auxCfg.lutEdgeDetect == LUT_ASYNC_SETTING);
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
  end

  logic [CW-1:0] wakeCycles;
  assign wakeCycles = deepWake ? CW'(BASE_CYCLES + OSC_CYCLES + REG_CYCLES)
                               : CW'(BASE_CYCLES);

  always_comb begin
    s_d       = s_q;
    s_d.rdata = RESET_BYTE;
    s_d.wake  = 1'b0;
    if (regRead) begin
      s_d.rdata = (regAddr == ADDR_SLEEP_CONTROL) ? s_q.sleepCtl : s_q.regCtl;
    end
    if (s_q.unlockCnt != 3'h0 && instrDone) begin
      s_d.unlockCnt = s_q.unlockCnt - 3'h1;
    end
    if (keyWritten) begin
      s_d.unlockCnt = 3'(UNLOCK_WINDOW);
    end
    if (regWrite && regAddr == ADDR_SLEEP_CONTROL) begin
      s_d.sleepCtl = regWdata & SLEEP_CONTROL_MASK;
    end
    if (regWrite && regAddr == ADDR_REGULATOR_CONTROL && s_q.unlockCnt != 3'h0) begin
      s_d.regCtl    = regWdata & REGULATOR_MASK;
      s_d.unlockCnt = 3'h0;
    end
    case (s_q.state)
      ST_ACTIVE: begin
        if (sleepInstr && s_q.sleepCtl[SLEEP_ENABLE_BIT]
            && modeValid) begin
          s_d.state         = ST_SLEEP;
          s_d.pwr.cpuHalted = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (allowed || brkSync) begin
          s_d.state   = ST_WAKE;
          s_d.latency = wakeCycles - CW'(1);
        end
      end
      ST_WAKE: begin
        if (s_q.latency != '0) begin
          s_d.latency = s_q.latency - CW'(1);
        end else begin
          s_d.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (auxCfg.brownoutConfigFuse != BROWNOUT_WAIT_READY || readySync) begin
          s_d.state         = ST_ACTIVE;
          s_d.pwr.cpuHalted = 1'b0;
          s_d.wake          = 1'b1;
        end
      end
      default: begin
        s_d.state = ST_ACTIVE;
      end
    endcase
    s_d.pwr.mainClkOn    = !(s_d.state == ST_SLEEP && clkStopped);
    s_d.pwr.lowFreqOscOn = !(s_d.state == ST_SLEEP && mode == MODE_POWER_DOWN)
                           || auxCfg.lowFreqUsers;
    s_d.pwr.regulatorFull = field3(s_d.regCtl, POWER_MODE_LSB) == DRIVE_FULL;
    s_d.pwr.leakReduce = s_d.state == ST_SLEEP && mode == MODE_POWER_DOWN && leak;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{state: ST_ACTIVE, sleepCtl: RESET_BYTE, regCtl: RESET_BYTE,
               unlockCnt: 3'h0, latency: '0, rdata: RESET_BYTE,
               pwr: '{mainClkOn: 1'b1, lowFreqOscOn: 1'b1, default: 1'b0},
               wake: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata  = s_q.rdata;
  assign powerOut  = s_q.pwr;
  assign wakeEvent = s_q.wake;

  a_reg_locked: assert property (@(posedge clk) disable iff (!rst_b)
    regWrite && regAddr == ADDR_REGULATOR_CONTROL && s_q.unlockCnt == 3'h0
    && !keyWritten |=> $stable(s_q.regCtl))
    else $error("regulator changed without unlock");

  a_sleep_enable: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_ACTIVE && sleepInstr && !s_q.sleepCtl[SLEEP_ENABLE_BIT]
    |=> s_q.state == ST_ACTIVE)
    else $error("slept without enable");

  sequence idle_wake_s;
    s_q.state == ST_SLEEP && mode == MODE_IDLE && (allowed || brkSync);
  endsequence
  a_idle_latency: assert property (@(posedge clk) disable iff (!rst_b)
    idle_wake_s |=> (s_q.state == ST_WAKE) [*6] ##1 s_q.state == ST_HOLD)
    else $error("idle wake latency not six");

  a_break_wake: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_SLEEP && brkSync |=> s_q.state == ST_WAKE)
    else $error("break did not wake");

  a_pin_powerdown: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_SLEEP && mode == MODE_POWER_DOWN && !brkSync
    && src == wake_src_t'(1) << ($bits(wake_src_t) - 1) |=> s_q.state == ST_SLEEP)
    else $error("sync pin woke power-down");

  a_detector_hold: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_HOLD && auxCfg.brownoutConfigFuse == BROWNOUT_WAIT_READY && !readySync
    |=> s_q.state == ST_HOLD)
    else $error("released before detector ready");

  a_release: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(s_q.pwr.cpuHalted) |-> s_q.wake && s_q.state == ST_ACTIVE)
    else $error("release without wake pulse");

  a_powerdown_clock: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_SLEEP && mode == MODE_POWER_DOWN |-> ##1
    (s_q.state != ST_SLEEP || !s_q.pwr.mainClkOn))
    else $error("main clock on in power-down");

  // Single-source patterns for gating checks
  localparam wake_src_t RTC_CMP_ONLY = '{rtcCompare: 1'b1, default: 1'b0};
  localparam wake_src_t OTHER_ONLY   = '{otherIrq: 1'b1, default: 1'b0};

  // Asleep in a given mode, no break pending
  sequence asleep_s(logic [2:0] m);
    s_q.state == ST_SLEEP && mode == m && !brkSync;
  endsequence

  // Wake taken where start-ups are added
  sequence deep_wake_s;
    s_q.state == ST_SLEEP && deepWake && (allowed || brkSync);
  endsequence

  a_async_pin: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_POWER_DOWN) ##0 (src.pinAsync) |=> s_q.state == ST_WAKE)
    else $error("async pin did not wake power-down");

  a_bus_standby: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_STANDBY) ##0 (src.busAddrMatch) |=> s_q.state == ST_WAKE)
    else $error("bus match did not wake standby");

  a_leak_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_POWER_DOWN) ##0 (leak
    && !(src.pinAsync || src.brownoutMonitor || src.rtcPeriodic)) |=> s_q.state == ST_SLEEP)
    else $error("woke power-down with leak reduce");

  a_lut_filtered: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_POWER_DOWN) ##0 ((auxCfg.lutFilterSelect != LUT_ASYNC_SETTING
    || auxCfg.lutEdgeDetect != LUT_ASYNC_SETTING) && !(src.pinAsync || src.brownoutMonitor
    || src.rtcPeriodic || src.busAddrMatch)) |=> s_q.state == ST_SLEEP)
    else $error("filtered lookup table woke power-down");

  a_rtc_standby: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_STANDBY) ##0 (!standbyCfg.rtcStandby && src == RTC_CMP_ONLY)
    |=> s_q.state == ST_SLEEP)
    else $error("rtc compare woke standby without run bit");

  a_rtc_powerdown: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_POWER_DOWN) ##0 (src == RTC_CMP_ONLY) |=> s_q.state == ST_SLEEP)
    else $error("rtc compare woke power-down");

  a_other_standby: assert property (@(posedge clk) disable iff (!rst_b)
    asleep_s(MODE_STANDBY) ##0 (src == OTHER_ONLY) |=> s_q.state == ST_SLEEP)
    else $error("stopped peripheral woke standby");

  a_wake_count: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_WAKE && s_q.latency != '0
    |=> s_q.state == ST_WAKE && s_q.latency == $past(s_q.latency) - CW'(1))
    else $error("wake latency count skipped");

  a_idle_clock: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_SLEEP && mode == MODE_IDLE |-> s_q.pwr.mainClkOn)
    else $error("main clock stopped in idle");

  a_deep_latency: assert property (@(posedge clk) disable iff (!rst_b)
    deep_wake_s |=> s_q.latency == CW'(BASE_CYCLES + OSC_CYCLES + REG_CYCLES - 1))
    else $error("deep wake latency wrong");

  a_lowfreq_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_SLEEP && mode == MODE_POWER_DOWN && !auxCfg.lowFreqUsers
    |=> s_q.state != ST_SLEEP || !s_q.pwr.lowFreqOscOn)
    else $error("low-frequency oscillator left running");

  a_hold_release: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_HOLD && (auxCfg.brownoutConfigFuse != BROWNOUT_WAIT_READY || readySync)
    |=> s_q.state == ST_ACTIVE && s_q.wake && !s_q.pwr.cpuHalted)
    else $error("hold not released");

  a_unlock_close: assert property (@(posedge clk) disable iff (!rst_b)
    regWrite && regAddr == ADDR_REGULATOR_CONTROL && s_q.unlockCnt != 3'h0 && !keyWritten
    |=> s_q.unlockCnt == 3'h0)
    else $error("unlock window left open");

  a_reserved_mode: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_ACTIVE && sleepInstr && !modeValid |=> s_q.state == ST_ACTIVE)
    else $error("slept in reserved mode");

  a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.state == ST_ACTIVE && sleepInstr && s_q.sleepCtl[SLEEP_ENABLE_BIT] && modeValid
    |=> s_q.state == ST_SLEEP && s_q.pwr.cpuHalted)
    else $error("sleep not entered");

  a_leak_asleep: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.pwr.leakReduce |-> s_q.state == ST_SLEEP)
    else $error("leak reduce while awake");

  a_wake_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.wake |=> !s_q.wake)
    else $error("wake pulse too long");
endmodule : sleep_mode_controller

// ### test/sleep_cpu_model.sv
// Model of the interrupt sources and the CPU service side.
// Assumes the bench pulses request for one cycle; the flags hold until service.
module sleep_cpu_model
  import sleep_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      wakeEvent,
  input  wire wake_src_t request,
  output      wake_src_t wakeSrc
);
  timeunit 1ns;
  timeprecision 100ps;

  initial wakeSrc = '0;

  always @(posedge clk) begin
    if (wakeEvent === 1'b1) begin
      wakeSrc <= #2 '0;
    end else if (request != '0) begin
      wakeSrc <= #2 wakeSrc | request;
    end
  end
endmodule : sleep_cpu_model

// ### test/sleep_mode_controller_test.sv
// Self-checking bench for the sleep controller.
// Assumes small start-up counts; latencies are compared as differences.
module sleep_mode_controller_test;
  import sleep_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC = 3;
  localparam int REG = 5;
  localparam wake_src_t PIN_S = 10'h200;
  localparam wake_src_t PIN_A = 10'h100;
  localparam wake_src_t RTC_P = 10'h040;
  localparam wake_src_t RTC_C = 10'h020;
  localparam wake_src_t BUS   = 10'h010;
  localparam wake_src_t LUT   = 10'h008;
  localparam wake_src_t OTHER = 10'h001;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [0:0]   regAddr = '0;
  logic [7:0]   regWdata = '0;
  logic         regWrite = 1'b0;
  logic         regRead = 1'b0;
  logic         sleepInstr = 1'b0;
  logic         keyWritten = 1'b0;
  logic         instrDone = 1'b0;
  logic         debugBreak = 1'b0;
  logic         brownoutReady = 1'b1;
  standby_cfg_t standbyCfg = '0;
  aux_cfg_t     auxCfg = '0;
  wake_src_t    request = '0;
  wake_src_t    wakeSrc;
  logic [7:0]   regRdata;
  power_out_t   powerOut;
  logic         wakeEvent;
  int           miscompares = 0;
  int           check_count = 0;
  int           idleLat;

  always #4 clk = ~clk;

  sleep_mode_controller #(.OSC_CYCLES(OSC), .REG_CYCLES(REG)) dut_u (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .sleepInstr(sleepInstr), .keyWritten(keyWritten),
    .instrDone(instrDone), .debugBreak(debugBreak), .wakeSrc(wakeSrc), .standbyCfg(standbyCfg),
    .auxCfg(auxCfg), .brownoutReady(brownoutReady), .powerOut(powerOut), .wakeEvent(wakeEvent));

  sleep_cpu_model model_u (.clk(clk), .wakeEvent(wakeEvent), .request(request),
                           .wakeSrc(wakeSrc));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic regWr(input logic [0:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : regWr

  task automatic rdChk(input logic [0:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(16'(regRdata), 16'(exp));
  endtask : rdChk

  task automatic unlockWr(input int gap, input logic [7:0] d);
    @(posedge clk);
    keyWritten <= 1'b1;
    @(posedge clk);
    keyWritten <= 1'b0;
    repeat (gap) begin
      @(posedge clk);
      instrDone <= 1'b1;
      @(posedge clk);
      instrDone <= 1'b0;
    end
    regWr(ADDR_REGULATOR_CONTROL, d);
  endtask : unlockWr

  task automatic sleepPulse;
    @(posedge clk);
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    @(negedge clk);
  endtask : sleepPulse

  // Enter a mode, raise sources; lat is -1 when no wake came, then break wakes
  task automatic trySleep(input logic [2:0] mode, input wake_src_t src, output int lat,
                          output power_out_t po);
    regWr(ADDR_SLEEP_CONTROL, {4'h0, mode, 1'b1});
    sleepPulse();
    @(posedge clk);
    request <= src;
    @(posedge clk);
    request <= '0;
    @(negedge clk);
    po = powerOut;
    lat = -1;
    for (int i = 0; i < 60 && lat < 0; i++) begin
      @(negedge clk);
      if (wakeEvent === 1'b1) lat = i;
    end
    if (lat < 0) begin
      @(posedge clk);
      debugBreak <= 1'b1;
      brownoutReady <= 1'b1;
      for (int i = 0; i < 60 && wakeEvent !== 1'b1; i++) @(negedge clk);
      chk(16'(wakeEvent), 16'h1);
      @(posedge clk);
      debugBreak <= 1'b0;
    end
    chk(16'(powerOut.cpuHalted), 16'h0);
    repeat (4) @(posedge clk);
  endtask : trySleep

  task automatic gate(input logic [2:0] mode, input wake_src_t src, input logic exp);
    int         lat;
    power_out_t po;
    trySleep(mode, src, lat, po);
    chk(16'(lat >= 0), 16'(exp));
  endtask : gate

  task automatic t_regs;
    rdChk(ADDR_SLEEP_CONTROL, RESET_BYTE);
    rdChk(ADDR_REGULATOR_CONTROL, RESET_BYTE);
    regWr(ADDR_SLEEP_CONTROL, 8'hff);
    rdChk(ADDR_SLEEP_CONTROL, SLEEP_CONTROL_MASK);
    regWr(ADDR_REGULATOR_CONTROL, 8'hff);
    rdChk(ADDR_REGULATOR_CONTROL, RESET_BYTE);
    unlockWr(UNLOCK_WINDOW, 8'hff);
    rdChk(ADDR_REGULATOR_CONTROL, RESET_BYTE);
    unlockWr(UNLOCK_WINDOW - 1, 8'hff);
    rdChk(ADDR_REGULATOR_CONTROL, REGULATOR_MASK);
    unlockWr(0, 8'h00);
    $display("Registers test done");
  endtask : t_regs

  task automatic t_enable;
    regWr(ADDR_SLEEP_CONTROL, {4'h0, MODE_IDLE, 1'b0});
    sleepPulse();
    chk(16'(powerOut.cpuHalted), 16'h0);
    regWr(ADDR_SLEEP_CONTROL, {4'h0, 3'h3, 1'b1});
    sleepPulse();
    chk(16'(powerOut.cpuHalted), 16'h0);
    $display("Enable test done");
  endtask : t_enable

  task automatic t_latency;
    int         l;
    power_out_t po;
    @(posedge clk);
    auxCfg.lowFreqUsers <= 1'b1;
    trySleep(MODE_IDLE, PIN_S, idleLat, po);
    chk(16'(po.mainClkOn), 16'h1);
    trySleep(MODE_STANDBY, PIN_A, l, po);
    chk(16'(l - idleLat), 16'(OSC + REG));
    chk(16'(po.mainClkOn), 16'h0);
    standbyCfg.mainClkStandby <= 1'b1;
    trySleep(MODE_STANDBY, PIN_S, l, po);
    chk(16'(l - idleLat), 16'h0);
    trySleep(MODE_POWER_DOWN, PIN_A, l, po);
    chk(16'(l - idleLat), 16'(OSC + REG));
    chk(16'({po.mainClkOn, po.lowFreqOscOn}), 16'h1);
    auxCfg.lowFreqUsers <= 1'b0;
    trySleep(MODE_POWER_DOWN, PIN_A, l, po);
    chk(16'({po.mainClkOn, po.lowFreqOscOn}), 16'h0);
    $display("Latency test done");
  endtask : t_latency

  task automatic t_gating;
    int         l;
    power_out_t po;
    gate(MODE_POWER_DOWN, PIN_S, 1'b0);
    gate(MODE_STANDBY, OTHER, 1'b0);
    gate(MODE_STANDBY, RTC_C, 1'b0);
    standbyCfg.rtcStandby <= 1'b1;
    gate(MODE_STANDBY, RTC_C, 1'b1);
    gate(MODE_POWER_DOWN, RTC_C, 1'b0);
    gate(MODE_POWER_DOWN, RTC_P, 1'b1);
    auxCfg.lutFilterSelect <= 2'h1;
    gate(MODE_POWER_DOWN, LUT, 1'b0);
    auxCfg.lutFilterSelect <= LUT_ASYNC_SETTING;
    gate(MODE_POWER_DOWN, LUT, 1'b1);
    gate(MODE_POWER_DOWN, BUS, 1'b1);
    gate(MODE_STANDBY, BUS, 1'b1);
    // leak bit used for power-down only
    unlockWr(0, 8'h10);
    trySleep(MODE_POWER_DOWN, BUS, l, po);
    chk({po.leakReduce, 15'(l >= 0)}, 16'h8000);
    gate(MODE_POWER_DOWN, LUT, 1'b0);
    unlockWr(0, {3'h0, 1'b1, 1'b0, DRIVE_FULL});
    trySleep(MODE_POWER_DOWN, BUS, l, po);
    chk({po.regulatorFull, po.leakReduce, 14'(l >= 0)}, 16'h8001);
    unlockWr(0, 8'h00);
    $display("Gating test done");
  endtask : t_gating

  task automatic t_brownout;
    int         l;
    power_out_t po;
    auxCfg.brownoutConfigFuse <= BROWNOUT_WAIT_READY;
    brownoutReady <= 1'b0;
    gate(MODE_IDLE, PIN_S, 1'b0);
    trySleep(MODE_IDLE, PIN_S, l, po);
    chk(16'(l), 16'(idleLat));
    $display("Brown-out test done");
  endtask : t_brownout

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #100000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_enable();
    t_latency();
    t_gating();
    t_brownout();
    conclude();
  end
endmodule : sleep_mode_controller_test
